/* File: core/scanner_channel_select.sv */
// Scanner channel capture, host channel command and correction lookup.
// Assumes pins are asynchronous, trigger strobes come from mclk_i logic.
`timescale 1ns/10ps
`include "scan_chan_consts.svh"

module scanner_channel_select #(
   parameter int SETS   = `NUM_SETS,
   parameter int POINTS = `NUM_POINTS
) (
   input  wire logic                    mclk_i,
   input  wire logic                    rst_i,
   input  wire logic [7:0]              channel_select_lines_n_i,
   input  wire logic                    channel_validate_n_i,
   input  wire logic                    meas_trigger_i,
   input  wire logic                    corr_meas_start_i,
   input  wire logic [5:0]              address_i,
   input  wire logic                    read_i,
   input  wire logic                    write_i,
   input  wire logic [31:0]             writedata_i,
   output logic [31:0]                  readdata_o,
   output logic                         waitrequest_o,
   output scan_chan_pkg::corr_sel_t     corr_sel_o,
   output logic                         search_busy_o
);
   import scan_chan_pkg::*;

   localparam int DEPTH = SETS * 256;
   localparam logic [7:0] LAST_PT = 8'(POINTS - 1);

   // ==========================================
   // Storage
   logic [31:0] point_frequency_setting_mem [DEPTH];  // Point frequencies
   logic [31:0] refa_mem [DEPTH];  // Primary references
   logic [31:0] refb_mem [DEPTH];  // Secondary references
   logic        on_mem   [DEPTH];  // Point on/off

   // ==========================================
   // State
   logic [7:0]    sel_q1, sel_q2;   // Select line synchroniser
   logic          val_q1, val_q2;   // Validate synchroniser
   logic          wait_r;           // Bus wait state
   logic [31:0]   rdata;            // Read data register
   logic          scan_en;          // Scanner interface on
   logic          multi;            // Multi-channel mode
   logic [2:0]    corr_en;          // Open, short, load
   logic [3:0]    ref_kind;         // Reference parameter kind
   logic [3:0]    meas_kind;        // Measured parameter kind
   logic [7:0]    channel;          // Current channel
   logic          range_err;        // Out of range code seen
   logic          src_pin;          // Last set from connector
   logic [7:0]    pidx;             // Edited point index
   logic [31:0]   test_point_frequency_setting;        // Active test frequency
   search_state_t state;            // Search machine
   logic [7:0]    ptr;              // Search pointer
   logic          match, busy_r;    // Search result, search busy flag
   logic [7:0]    mpt;              // Matching point
   corr_sel_t     sel;              // Output register

   // Next values
   logic          next_wait;
   logic [31:0]   next_rdata;
   logic          next_scan_en, next_multi;
   logic [2:0]    next_corr_en;
   logic [3:0]    next_ref_kind, next_meas_kind;
   logic [7:0]    next_channel;
   logic          next_range_err, next_src_pin;
   logic [7:0]    next_pidx;
   logic [31:0]   next_test_point_frequency_setting;
   search_state_t next_state;
   logic [7:0]    next_ptr, next_mpt;
   logic          next_match, next_busy;
   corr_sel_t     next_sel;
   // Memory write strobes
   logic          we_point_frequency_setting, we_on, we_refa, we_refb;

   // ==========================================
   // Helpers
   // Address decode used by read and write paths
   function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
      hit = (a == off);
   endfunction : hit

   // Memory index from set and point
   function automatic logic [14:0] mix(input logic [7:0] c, input logic [7:0] p);
      mix = {c[6:0], p};
   endfunction : mix

   logic       do_wr;   // Write completes this edge
   logic       do_rd;   // Read captured this edge
   logic       capture; // Connector capture event
   logic [7:0] pin_ch;  // Decoded connector channel
   logic [7:0] host_ch; // Host command channel
   logic [14:0] eidx;   // Edit index
   logic [14:0] sidx;   // Search index

   assign do_wr   = write_i && !wait_r;
   assign do_rd   = read_i && wait_r;
   assign pin_ch  = ~sel_q2;
   assign capture = scan_en && !val_q2 && (meas_trigger_i || corr_meas_start_i);
   assign host_ch = writedata_i[7:0];
   assign eidx    = mix(channel, pidx);
   assign sidx    = mix(channel, ptr);
   // ==========================================
   // Next-state logic
   always_comb begin
      next_wait      = !((read_i || write_i) && wait_r);
      next_rdata     = rdata;
      next_scan_en   = scan_en;
      next_multi     = multi;
      next_corr_en   = corr_en;
      next_ref_kind  = ref_kind;
      next_meas_kind = meas_kind;
      next_channel   = channel;
      next_range_err = range_err;
      next_src_pin   = src_pin;
      next_pidx      = pidx;
      next_test_point_frequency_setting = test_point_frequency_setting;
      next_state     = state;
      next_ptr       = ptr;
      next_match     = match;
      next_mpt       = mpt;
      we_point_frequency_setting        = 1'b0;
      we_on          = 1'b0;
      we_refa        = 1'b0;
      we_refb        = 1'b0;
      // Read data mux, loaded when request first seen
      if (do_rd) begin
         next_rdata = `RST_WORD;
         if (hit(address_i, `OFF_CTRL)) begin
            next_rdata[`CTRL_SCAN]  = scan_en;
            next_rdata[`CTRL_MULTI] = multi;
            next_rdata[`CTRL_OPEN]  = corr_en[0];
            next_rdata[`CTRL_SHORT] = corr_en[1];
            next_rdata[`CTRL_LOAD]  = corr_en[2];
         end else if (hit(address_i, `OFF_REFERENCE_PARAMETER_KIND)) begin
            next_rdata[`REFERENCE_PARAMETER_KIND_REF_LSB +: 4]  = ref_kind;
            next_rdata[`REFERENCE_PARAMETER_KIND_MEAS_LSB +: 4] = meas_kind;
         end else if (hit(address_i, `OFF_CHAN)) begin
            next_rdata[7:0] = channel;
         end else if (hit(address_i, `OFF_STAT)) begin
            next_rdata[7:0]              = channel;
            next_rdata[`STAT_RANGE]      = range_err;
            next_rdata[`STAT_MATCH]      = match;
            next_rdata[`STAT_PT_LSB +: 8] = mpt;
            next_rdata[`STAT_BUSY]       = (state != S_IDLE);
            next_rdata[`STAT_SRC]        = src_pin;
         end else if (hit(address_i, `OFF_PIDX)) begin
            next_rdata[7:0] = pidx;
         end else if (hit(address_i, `OFF_PFREQ)) begin
            next_rdata = point_frequency_setting_mem[eidx];
         end else if (hit(address_i, `OFF_PON)) begin
            next_rdata[0] = on_mem[eidx];
         end else if (hit(address_i, `OFF_REFA)) begin
            next_rdata = refa_mem[eidx];
         end else if (hit(address_i, `OFF_REFB)) begin
            next_rdata = refb_mem[eidx];
         end else if (hit(address_i, `OFF_TFREQ)) begin
            next_rdata = test_point_frequency_setting;
         end
      end

      // Register writes
      if (do_wr) begin
         if (hit(address_i, `OFF_CTRL)) begin
            next_scan_en = writedata_i[`CTRL_SCAN];
            // Multi only sticks with the interface on
            next_multi   = writedata_i[`CTRL_MULTI] && writedata_i[`CTRL_SCAN];
            next_corr_en = {writedata_i[`CTRL_LOAD], writedata_i[`CTRL_SHORT],
                            writedata_i[`CTRL_OPEN]};
         end else if (hit(address_i, `OFF_REFERENCE_PARAMETER_KIND)) begin
            next_ref_kind  = writedata_i[`REFERENCE_PARAMETER_KIND_REF_LSB +: 4];
            next_meas_kind = writedata_i[`REFERENCE_PARAMETER_KIND_MEAS_LSB +: 4];
         end else if (hit(address_i, `OFF_STAT)) begin
            // Write one clears the range flag
            if (writedata_i[`STAT_RANGE]) begin
               next_range_err = 1'b0;
            end
         end else if (hit(address_i, `OFF_PIDX)) begin
            if (writedata_i[7:0] <= LAST_PT) begin
               next_pidx = writedata_i[7:0];
            end
         end else if (hit(address_i, `OFF_PFREQ)) begin
            we_point_frequency_setting = 1'b1;
         end else if (hit(address_i, `OFF_PON)) begin
            we_on = 1'b1;
         end else if (hit(address_i, `OFF_REFA)) begin
            we_refa = 1'b1;
         end else if (hit(address_i, `OFF_REFB)) begin
            we_refb = 1'b1;
         end else if (hit(address_i, `OFF_TFREQ)) begin
            next_test_point_frequency_setting = writedata_i;
         end
      end

      // Connector capture on a measurement event
      if (capture) begin
         if (pin_ch <= `MAX_CHAN) begin
            next_channel = pin_ch;
            next_src_pin = 1'b1;
         end else begin
            next_range_err = 1'b1;  // Code above last set refused
         end
      end

      // Host command wins over a capture in the same cycle
      if (do_wr && hit(address_i, `OFF_CHAN)) begin
         if (host_ch <= `MAX_CHAN) begin
            next_channel = host_ch;
            next_src_pin = 1'b0;
         end else begin
            next_range_err = 1'b1;
         end
      end

      // Frequency search over the selected set
      case (state)
         S_IDLE: begin
            if (capture || meas_trigger_i) begin
               next_state = S_SEARCH;
               next_ptr   = 8'h00;
            end
         end
         S_SEARCH: begin
            if (on_mem[sidx] && point_frequency_setting_mem[sidx] == test_point_frequency_setting) begin
               next_match = 1'b1;
               next_mpt   = ptr;
               next_state = S_DONE;
            end else if (ptr == LAST_PT) begin
               next_match = 1'b0;
               next_state = S_DONE;
            end else begin
               next_ptr = ptr + 8'h01;
            end
         end
         S_DONE: begin
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      next_busy = (next_state != S_IDLE);  // Registered so the busy pin comes from a flop
      // Output selection, correction only on a match
      next_sel.channel   = next_channel;
      next_sel.multi     = next_multi;
      next_sel.match     = next_match;
      next_sel.point     = next_mpt;
      next_sel.open_en   = corr_en[0] && next_match;
      next_sel.short_en  = corr_en[1] && next_match;
      next_sel.load_en   = corr_en[2] && next_match;
      next_sel.ref_kind  = next_ref_kind;
      next_sel.meas_kind = next_meas_kind;
   end

   // ==========================================
   // Registers
   always_ff @(posedge mclk_i) begin
      // Pin synchronisers, no reset needed for data path
      sel_q1 <= channel_select_lines_n_i;
      sel_q2 <= sel_q1;
      val_q1 <= channel_validate_n_i;
      val_q2 <= val_q1;
      if (rst_i) begin
         wait_r    <= 1'b1;
         rdata     <= `RST_WORD;
         scan_en   <= 1'b0;
         multi     <= 1'b0;
         corr_en   <= 3'h0;
         ref_kind  <= 4'h0;
         meas_kind <= 4'h0;
         channel   <= `RST_CHAN;
         range_err <= 1'b0;
         src_pin   <= 1'b0;
         pidx      <= 8'h00;
         test_point_frequency_setting <= `RST_WORD;
         state     <= S_IDLE;
         ptr       <= 8'h00;
         match     <= 1'b0;
         mpt       <= 8'h00;
         busy_r    <= 1'b0;
         sel       <= '0;
      end else begin
         wait_r    <= next_wait;
         rdata     <= next_rdata;
         scan_en   <= next_scan_en;
         multi     <= next_multi;
         corr_en   <= next_corr_en;
         ref_kind  <= next_ref_kind;
         meas_kind <= next_meas_kind;
         channel   <= next_channel;
         range_err <= next_range_err;
         src_pin   <= next_src_pin;
         pidx      <= next_pidx;
         test_point_frequency_setting <= next_test_point_frequency_setting;
         state     <= next_state;
         ptr       <= next_ptr;
         match     <= next_match;
         mpt       <= next_mpt;
         busy_r    <= next_busy;
         sel       <= next_sel;
      end
   end

   // Correction table writes, unreset storage
   always_ff @(posedge mclk_i) begin
      if (we_point_frequency_setting) begin
         point_frequency_setting_mem[eidx] <= writedata_i;
      end
      if (we_on) begin
         on_mem[eidx] <= writedata_i[0];
      end
      if (we_refa) begin
         refa_mem[eidx] <= writedata_i;
      end
      if (we_refb) begin
         refb_mem[eidx] <= writedata_i;
      end
   end

   // ==========================================
   // Outputs
   assign readdata_o    = rdata;
   assign waitrequest_o = wait_r;
   assign corr_sel_o    = sel;
   assign search_busy_o = busy_r;
endmodule : scanner_channel_select

/* File: core/scan_chan_consts.svh */
// Constants for the scanner channel select block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef SCAN_CHAN_CONSTS_SVH
`define SCAN_CHAN_CONSTS_SVH
// ==========================================
// Register byte offsets
`define OFF_CTRL   6'h00
`define OFF_REFERENCE_PARAMETER_KIND   6'h04
`define OFF_CHAN   6'h08
`define OFF_STAT   6'h0c
`define OFF_PIDX   6'h10
`define OFF_PFREQ  6'h14
`define OFF_PON    6'h18
`define OFF_REFA   6'h1c
`define OFF_REFB   6'h20
`define OFF_TFREQ  6'h24
// ==========================================
// Control register fields
`define CTRL_SCAN  0
`define CTRL_MULTI 1
`define CTRL_OPEN  2
`define CTRL_SHORT 3
`define CTRL_LOAD  4
// Function register fields
`define REFERENCE_PARAMETER_KIND_REF_LSB  0
`define REFERENCE_PARAMETER_KIND_MEAS_LSB 8
// Status register fields
`define STAT_RANGE 8
`define STAT_MATCH 9
`define STAT_PT_LSB 10
`define STAT_BUSY  18
`define STAT_SRC   19
// ==========================================
// Sizes and limits
`define NUM_SETS   128
`define NUM_POINTS 201
`define MAX_CHAN   8'h7f
`define RST_CHAN   8'h00
`define RST_WORD   32'h0000_0000
`endif

/* File: core/scan_chan_pkg.sv */
// Types shared by the scanner channel select block.
// Assumes the constants header is compiled alongside.
package scan_chan_pkg;
   // ==========================================
   // Correction selection handed to the measuring path
   typedef struct packed {
      logic [7:0] channel;   // Current channel, for display
      logic       multi;     // Per-channel correction mode
      logic       match;     // Test frequency found in set
      logic [7:0] point;     // Matching point index
      logic       open_en;   // Open correction applied
      logic       short_en;  // Short correction applied
      logic       load_en;   // Load correction applied
      logic [3:0] ref_kind;  // Parameter kind of references
      logic [3:0] meas_kind; // Parameter kind measured
   } corr_sel_t;
   // Frequency search states
   typedef enum logic [1:0] {
      S_IDLE,
      S_SEARCH,
      S_DONE
   } search_state_t;
endpackage : scan_chan_pkg

/* File: testbench/scan_chan_props.sv */
// Port checker for the scanner channel select block.
// Assumes the package is compiled first; bound to every block instance.
`timescale 1ns/10ps
module scan_chan_props #(
   parameter int SETS   = 128,
   parameter int POINTS = 201
) (
   input wire logic                      mclk_i,
   input wire logic                      rst_i,
   input wire logic [7:0]                channel_select_lines_n_i,
   input wire logic                      channel_validate_n_i,
   input wire logic                      meas_trigger_i,
   input wire logic                      corr_meas_start_i,
   input wire logic [5:0]                address_i,
   input wire logic                      read_i,
   input wire logic                      write_i,
   input wire logic [31:0]               writedata_i,
   input wire logic [31:0]               readdata_o,
   input wire logic                      waitrequest_o,
   input wire scan_chan_pkg::corr_sel_t  corr_sel_o,
   input wire logic                      search_busy_o
);
   import scan_chan_pkg::*;
   // ==========================================
   // Assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic ev; // Anything allowed to move the channel
   assign ev = meas_trigger_i | corr_meas_start_i | write_i;
   a_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("waitrequest did not drop");
   a_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("waitrequest low too long");
   a_reset_clear: assert property ($fell(rst_i) |-> waitrequest_o && corr_sel_o == '0 && !search_busy_o)
      else $error("outputs not cleared by reset");
   a_chan_range: assert property (corr_sel_o.channel <= 8'h7f)
      else $error("channel beyond last set");
   a_chan_held: assert property ($changed(corr_sel_o.channel) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
      else $error("channel moved without event");
   a_nomatch_off: assert property (!corr_sel_o.match |-> !(corr_sel_o.open_en || corr_sel_o.short_en || corr_sel_o.load_en))
      else $error("correction on without match");
   a_point_range: assert property (corr_sel_o.match |-> corr_sel_o.point < POINTS)
      else $error("match point out of range");
   a_search_bound: assert property ($rose(search_busy_o) |-> ##[1:210] !search_busy_o)
      else $error("search too long");
   a_unmapped_zero: assert property (read_i && !waitrequest_o && address_i > 6'h24 |-> readdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!read_i |=> $stable(readdata_o))
      else $error("read data moved without read");
   c_trig: cover property (meas_trigger_i && !channel_validate_n_i);
   c_match: cover property (corr_sel_o.match && corr_sel_o.load_en);
   c_start: cover property (corr_meas_start_i);
endmodule : scan_chan_props
bind scanner_channel_select scan_chan_props #(.SETS(SETS), .POINTS(POINTS)) u_props (
   .mclk_i                   (mclk_i),
   .rst_i                    (rst_i),
   .channel_select_lines_n_i (channel_select_lines_n_i),
   .channel_validate_n_i     (channel_validate_n_i),
   .meas_trigger_i           (meas_trigger_i),
   .corr_meas_start_i        (corr_meas_start_i),
   .address_i                (address_i),
   .read_i                   (read_i),
   .write_i                  (write_i),
   .writedata_i              (writedata_i),
   .readdata_o               (readdata_o),
   .waitrequest_o            (waitrequest_o),
   .corr_sel_o               (corr_sel_o),
   .search_busy_o            (search_busy_o)
);

/* File: testbench/scanner_model.sv */
// Scanner controller model driving the channel pins.
// Assumes pins are pulled high when released.
`timescale 1ns/10ps
module scanner_model (
   input wire logic        mclk_i,
   input wire logic [7:0]  code_i,       // Channel wanted
   input wire logic        drive_i,      // Lines driven
   input wire logic        valid_i,      // Code announced valid
   output logic [7:0]      lines_n_o = 8'hff,
   output logic            valid_n_o = 1'b1
);
   logic [7:0] next_lines_n; // Pin levels to come
   logic       next_valid_n; // Validate level to come
   // Released lines float up to the pull-up
   always_comb begin
      next_lines_n = drive_i ? ~code_i : 8'hff;
      next_valid_n = ~valid_i;
   end
   // Pins change just after the edge
   always_ff @(posedge mclk_i) begin
      lines_n_o <= next_lines_n;
      valid_n_o <= next_valid_n;
   end
endmodule : scanner_model

/* File: testbench/tb.sv */
// Self-checking bench for the scanner channel select block.
// Assumes the package, constants header and scanner model are compiled.
`timescale 1ns/10ps
`include "scan_chan_consts.svh"
module tb;
   import scan_chan_pkg::*;
   logic mclk_i = 1'b0, rst_i = 1'b1, trig = 1'b0, cst = 1'b0, rd = 1'b0, wr = 1'b0;
   logic drv = 1'b0, vld = 1'b0, wreq, busy, vn;
   logic [7:0] code = 8'h00, ln, c, prev;
   logic [5:0] addr = 6'h00;
   logic [31:0] wd = 32'h0, rdat, q;
   corr_sel_t sel;
   int error_cnt = 0, comparisons = 0, w, r;
   // ==========================================
   // Clock, partner and block
   always #2 mclk_i = ~mclk_i;
   scanner_model u_scan (.mclk_i(mclk_i), .code_i(code), .drive_i(drv), .valid_i(vld),
      .lines_n_o(ln), .valid_n_o(vn));
   scanner_channel_select dut (.mclk_i(mclk_i), .rst_i(rst_i), .channel_select_lines_n_i(ln),
      .channel_validate_n_i(vn), .meas_trigger_i(trig), .corr_meas_start_i(cst), .address_i(addr),
      .read_i(rd), .write_i(wr), .writedata_i(wd), .readdata_o(rdat), .waitrequest_o(wreq),
      .corr_sel_o(sel), .search_busy_o(busy));
   // ==========================================
   // Helpers
   function automatic logic [7:0] pin_chan(input logic [7:0] n);
      return ~n; // Negative true lines
   endfunction : pin_chan
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w_en, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      addr <= a;
      wd <= d;
      rd <= !w_en;
      wr <= w_en;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         $display("[FAIL] %0t bus wait timed out", $time);
      end
   endtask : bus
   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rchk
   // Event pulse, then wait out the search
   task automatic pulse(input logic start);
      int n;
      @(posedge mclk_i);
      trig <= !start;
      cst <= start;
      @(posedge mclk_i);
      trig <= 1'b0;
      cst <= 1'b0;
      n = 0;
      repeat (2) @(posedge mclk_i);
      chk(busy, 32'h1);
      while (busy !== 1'b0 && n < 300) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 300) begin
         error_cnt++;
         $display("[FAIL] %0t search did not finish", $time);
      end
      repeat (2) @(posedge mclk_i);
   endtask : pulse
   task automatic end_sim();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // ==========================================
   // Watchdog
   initial begin
      #100000;
      error_cnt++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(34483));
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      chk(sel, '0);
      rchk(`OFF_CHAN, `RST_WORD);
      bus(1'b1, `OFF_CTRL, 32'h2);
      rchk(`OFF_CTRL, 32'h0);
      bus(1'b1, `OFF_CTRL, 32'h1f);
      rchk(`OFF_CTRL, 32'h1f);
      bus(1'b1, `OFF_REFERENCE_PARAMETER_KIND, 32'h0503);
      repeat (3) @(posedge mclk_i);
      chk({sel.multi, sel.ref_kind, sel.meas_kind}, {1'b1, 4'h3, 4'h5});
      prev = 8'h00;
      for (int i = 0; i < 8; i++) begin
         c = (i == 0) ? 8'h7f : 8'($urandom_range(127, 0));
         code <= c;
         drv <= 1'b1;
         vld <= 1'b1;
         repeat (5) @(posedge mclk_i);
         chk(sel.channel, prev);
         pulse(i[0]);
         chk(sel.channel, pin_chan(ln));
         bus(1'b0, `OFF_STAT, 32'h0);
         chk({q[19], q[7:0]}, {1'b1, c});
         vld <= 1'b0;
         code <= ~c & 8'h7f;
         repeat (5) @(posedge mclk_i);
         pulse(1'b0);
         chk(sel.channel, c);
         prev = c;
      end
      code <= 8'h80 | 8'($urandom_range(127, 0));
      vld <= 1'b1;
      repeat (5) @(posedge mclk_i);
      pulse(1'b0);
      bus(1'b0, `OFF_STAT, 32'h0);
      chk({q[8], q[7:0], sel.channel}, {1'b1, prev, prev});
      vld <= 1'b0;
      w = $urandom_range(127, 0);
      bus(1'b1, `OFF_CHAN, 32'(w));
      repeat (2) @(posedge mclk_i);
      chk(sel.channel, 8'(w));
      bus(1'b1, `OFF_CHAN, 32'h80);
      bus(1'b1, 6'h3c, 32'hffff_ffff);
      rchk(`OFF_CHAN, 32'(w));
      rchk(6'h3c, 32'h0);
      bus(1'b0, `OFF_STAT, 32'h0);
      chk(q[8], 32'h1);
      bus(1'b1, `OFF_STAT, 32'h100);
      bus(1'b0, `OFF_STAT, 32'h0);
      chk({q[8], q[19], q[7:0]}, {1'b0, 1'b0, 8'(w)});
      for (int p = 0; p < 201; p++) begin
         bus(1'b1, `OFF_PIDX, 32'(p));
         bus(1'b1, `OFF_PFREQ, 32'(p + 1000));
         bus(1'b1, `OFF_PON, 32'h0);
      end
      bus(1'b1, `OFF_PIDX, 32'd200);
      bus(1'b1, `OFF_PFREQ, 32'h1234);
      bus(1'b1, `OFF_PIDX, 32'd201);
      rchk(`OFF_PIDX, 32'd200);
      r = $urandom();
      bus(1'b1, `OFF_REFA, 32'(r));
      bus(1'b1, `OFF_REFB, ~32'(r));
      rchk(`OFF_REFA, 32'(r));
      rchk(`OFF_REFB, ~32'(r));
      rchk(`OFF_PFREQ, 32'h1234);
      for (int j = 0; j < 3; j++) begin
         bus(1'b1, `OFF_PON, 32'(j != 1));
         bus(1'b1, `OFF_TFREQ, (j == 2) ? 32'h1235 : 32'h1234);
         pulse(1'b0);
         chk({sel.match, sel.point, sel.open_en, sel.short_en, sel.load_en},
             (j == 0) ? {1'b1, 8'd200, 3'b111} : {1'b0, 8'd200, 3'b000});
         bus(1'b0, `OFF_STAT, 32'h0);
         chk({q[9], q[17:10]}, {(j == 0), 8'd200});
      end
      rchk(`OFF_TFREQ, 32'h1235);
      end_sim();
   end
endmodule : tb
